// ---- rtl/gpio_port_bank.sv ----
// Configurable I/O port bank: latches, mode registers, pin drivers, AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module gpio_port_bank
  import gpio_bank_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tristate_fuse,
  input wire logic [1:0] clk_src_sel,
  input wire logic ext_reset_sel,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n,
  output logic [NUM_PINS-1:0] pu_strong,
  output logic [NUM_PINS-1:0] pu_weak,
  output logic [NUM_PINS-1:0] pu_very_weak,
  output logic [NUM_PINS-1:0] pd_strong
);

  // ==========================================================
  // Register decode
  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_LATCH = 3'h1,
    K_MODE_A = 3'h2,
    K_MODE_B = 3'h3,
    K_CTRL = 3'h4,
    K_GPI = 3'h5,
    K_BITOP = 3'h6,
    K_COUNT = 3'h7
  } reg_kind_t;

  function automatic logic [2:0] reg_port(input logic [7:0] idx);
    case (idx)
      IDX_P1_LATCH, IDX_P1_MODE_A, IDX_P1_MODE_B: reg_port = 3'h1;
      IDX_P2_LATCH, IDX_P2_MODE_A, IDX_P2_MODE_B: reg_port = 3'h2;
      IDX_P3_LATCH, IDX_P3_MODE_A, IDX_P3_MODE_B: reg_port = 3'h3;
      IDX_P4_LATCH, IDX_P4_MODE_A, IDX_P4_MODE_B: reg_port = 3'h4;
      default: reg_port = 3'h0;
    endcase
  endfunction

  function automatic reg_kind_t reg_kind(input logic [AXI_ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[IDX_MSB:IDX_LSB];
    case (idx)
      IDX_P0_LATCH, IDX_P1_LATCH, IDX_P2_LATCH,
      IDX_P3_LATCH, IDX_P4_LATCH: reg_kind = K_LATCH;
      IDX_P0_MODE_A, IDX_P1_MODE_A, IDX_P2_MODE_A,
      IDX_P3_MODE_A, IDX_P4_MODE_A: reg_kind = K_MODE_A;
      IDX_P0_MODE_B, IDX_P1_MODE_B, IDX_P2_MODE_B,
      IDX_P3_MODE_B, IDX_P4_MODE_B: reg_kind = K_MODE_B;
      IDX_ANALOG_CTRL: reg_kind = K_CTRL;
      IDX_GPI_EN: reg_kind = K_GPI;
      IDX_BIT_OP: reg_kind = K_BITOP;
      IDX_PIN_COUNT: reg_kind = K_COUNT;
      default: reg_kind = K_NONE;
    endcase
    // The latch view alias exists only for port data registers
    if (a[1:0] != 2'h0 || a[AXI_ADDR_W-1] || (a[VIEW_BIT] && reg_kind != K_LATCH)) begin
      reg_kind = K_NONE;
    end
  endfunction

  // ==========================================================
  // State
  typedef struct packed {
    logic [NUM_PINS-1:0] latch;
    logic [NUM_PINS-1:0] mode_a;
    logic [NUM_PINS-1:0] mode_b;
    logic [NUM_PINS-1:0] boost_a;
    logic [NUM_PINS-1:0] boost_b;
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe_n;
    logic [NUM_PINS-1:0] pus;
    logic [NUM_PINS-1:0] puw;
    logic [NUM_PINS-1:0] puv;
    logic [NUM_PINS-1:0] pds;
    logic [7:0] ctrl;
    logic [7:0] gpi_en;
    logic aw_held;
    logic w_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [W_KEEP-1:0] w_data;
    logic [1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  // ==========================================================
  // Pin environment
  logic dac_on;
  logic adc_on;
  logic cmp_on;
  logic [NUM_PINS-1:0] eff_a;
  logic [NUM_PINS-1:0] eff_b;
  logic [NUM_PINS-1:0] m_qb;
  logic [NUM_PINS-1:0] m_pp;
  logic [NUM_PINS-1:0] m_in;
  logic [NUM_PINS-1:0] m_od;
  logic [NUM_PINS-1:0] lost;
  logic [NUM_PINS-1:0] gpi_mask;
  logic [NUM_PINS-1:0] in_en;
  logic [NUM_PINS-1:0] sensed;
  logic [5:0] lost_cnt;
  logic [5:0] pin_count;
  logic [NUM_PINS-1:0] c_out;
  logic [NUM_PINS-1:0] c_oe_n;
  logic [NUM_PINS-1:0] c_pus;
  logic [NUM_PINS-1:0] c_puw;
  logic [NUM_PINS-1:0] c_puv;
  logic [NUM_PINS-1:0] c_pds;

  assign cmp_on = s_ff.ctrl[CTRL_CMP_A] | s_ff.ctrl[CTRL_CMP_B];
  assign adc_on = s_ff.ctrl[CTRL_CONV_EN] & !s_ff.ctrl[CTRL_CONV_DAC];
  assign dac_on = s_ff.ctrl[CTRL_CONV_EN] & s_ff.ctrl[CTRL_CONV_DAC];

  // DAC outputs override software modes
  assign eff_a = s_ff.mode_a | (dac_on ? DAC_MASK : '0); // [RULE16]
  assign eff_b = s_ff.mode_b & ~(dac_on ? DAC_MASK : '0); // [RULE16]
  assign m_qb = ~eff_a & ~eff_b;
  assign m_pp = ~eff_a & eff_b;
  assign m_in = eff_a & ~eff_b;
  assign m_od = eff_a & eff_b;

  assign gpi_mask = NUM_PINS'(s_ff.gpi_en) << GPI_PORT_LSB;

  // Pins lost to clock and reset options; count of usable pins
  always_comb begin
    lost = '0;
    lost_cnt = 6'h0;
    if (clk_src_sel == CLK_XTAL) begin
      lost[XTAL_IN_PIN] = 1'b1; // [RULE20]
      lost[XTAL_OUT_PIN] = 1'b1; // [RULE20]
      lost_cnt = 6'h2;
    end else if (clk_src_sel == CLK_EXT) begin
      lost[XTAL_IN_PIN] = 1'b1; // [RULE20]
      lost_cnt = 6'h1;
    end
    if (ext_reset_sel) begin
      lost[RST_PIN] = 1'b1; // [RULE20]
      lost_cnt = lost_cnt + 6'h1;
    end
    pin_count = MAX_IO_PINS - lost_cnt; // [RULE20]
  end

  // Disabled input buffers read as zero so floating pins cannot toggle logic
  assign in_en = ~lost
    & (s_ff.ctrl[CTRL_PDOWN] ? (WAKE_MASK | gpi_mask) : '1) // [RULE5] [RULE6]
    & ~(cmp_on ? (CMP_MASK & m_in) : '0) // [RULE14]
    & ~(adc_on ? (ADC_MASK & m_in) : '0); // [RULE15]
  assign sensed = pin_in & in_en;

  // ==========================================================
  // Pin drivers
  for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
    gpio_pin_cell u_cell (
      .mode({eff_a[k], eff_b[k]}), // [RULE1]
      .latch(s_ff.latch[k]),
      .level(pin_in[k]),
      .boost(s_ff.boost_a[k] | s_ff.boost_b[k]),
      .lost(lost[k]),
      .drv_out(c_out[k]),
      .drv_oe_n(c_oe_n[k]),
      .pu_strong(c_pus[k]),
      .pu_weak(c_puw[k]),
      .pu_very_weak(c_puv[k]),
      .pd_strong(c_pds[k])
    );
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic [2:0] wp;
    logic [2:0] rp;
    logic [2:0] bp;
    logic [2:0] bb;
    logic [PORT_W-1:0] byte_v;
    wp = reg_port(s_ff.aw_addr[IDX_MSB:IDX_LSB]);
    rp = reg_port(araddr[IDX_MSB:IDX_LSB]);
    bp = s_ff.w_data[BITOP_PORT_LSB +: 3];
    bb = s_ff.w_data[BITOP_BIT_LSB +: 3];
    byte_v = s_ff.latch[bp * PORT_W +: PORT_W];
    nxt_s = s_ff;

    // Write address and data are taken in either order
    if (awvalid && s_ff.awready) begin
      nxt_s.aw_held = 1'b1;
      nxt_s.aw_addr = awaddr;
    end
    if (wvalid && s_ff.wready) begin
      nxt_s.w_held = 1'b1;
      nxt_s.w_data = wdata[W_KEEP-1:0];
      nxt_s.w_strb = wstrb[1:0];
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end

    if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid) begin
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = RESP_OKAY;
      case (reg_kind(s_ff.aw_addr))
        K_LATCH: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.latch[wp * PORT_W +: PORT_W] = s_ff.w_data[PORT_W-1:0]; // [RULE22]
          end
        end
        K_MODE_A: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.mode_a[wp * PORT_W +: PORT_W] = s_ff.w_data[PORT_W-1:0]; // [RULE22]
          end
        end
        K_MODE_B: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.mode_b[wp * PORT_W +: PORT_W] = s_ff.w_data[PORT_W-1:0]; // [RULE22]
          end
        end
        K_CTRL: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.ctrl = s_ff.w_data[7:0] & CTRL_MASK;
          end
        end
        K_GPI: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.gpi_en = s_ff.w_data[7:0];
          end
        end
        K_BITOP: begin
          // Whole latch byte is read, one bit changed, all eight written back
          if (&s_ff.w_strb && (32'(bp) < NUM_PORTS)) begin
            case (s_ff.w_data[BITOP_OP_LSB +: 2])
              OP_CLR: byte_v[bb] = 1'b0; // [RULE19]
              OP_SET: byte_v[bb] = 1'b1; // [RULE19]
              OP_CPL: byte_v[bb] = !byte_v[bb]; // [RULE18]
              default: byte_v[bb] = byte_v[bb];
            endcase
            nxt_s.latch[bp * PORT_W +: PORT_W] = byte_v; // [RULE19]
          end
        end
        K_COUNT: begin
          nxt_s.bresp = RESP_OKAY;
        end
        default: begin
          nxt_s.bresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_s.awready = !nxt_s.aw_held && !nxt_s.bvalid;
    nxt_s.wready = !nxt_s.w_held && !nxt_s.bvalid;

    // Read channel: one read under way at a time
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
      nxt_s.arready = 1'b1;
    end
    if (arvalid && s_ff.arready) begin
      nxt_s.arready = 1'b0;
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = RESP_OKAY;
      nxt_s.rdata = '0;
      case (reg_kind(araddr))
        K_LATCH: begin
          if (araddr[VIEW_BIT]) begin
            nxt_s.rdata[PORT_W-1:0] = s_ff.latch[rp * PORT_W +: PORT_W]; // [RULE18]
          end else begin
            nxt_s.rdata[PORT_W-1:0] = sensed[rp * PORT_W +: PORT_W]; // [RULE17]
          end
        end
        K_MODE_A: nxt_s.rdata[PORT_W-1:0] = s_ff.mode_a[rp * PORT_W +: PORT_W];
        K_MODE_B: nxt_s.rdata[PORT_W-1:0] = s_ff.mode_b[rp * PORT_W +: PORT_W];
        K_CTRL: nxt_s.rdata[7:0] = s_ff.ctrl;
        K_GPI: nxt_s.rdata[7:0] = s_ff.gpi_en;
        K_COUNT: nxt_s.rdata[5:0] = pin_count;
        K_BITOP: nxt_s.rdata = '0;
        default: nxt_s.rresp = RESP_SLVERR;
      endcase
    end

    // Strong pull-up pulse: stage a on a latch rise, stage b one clock later
    nxt_s.boost_a = nxt_s.latch & ~s_ff.latch & m_qb; // [RULE9]
    nxt_s.boost_b = s_ff.boost_a; // [RULE9]

    // Registered pin drive, one clock behind the state it reflects
    nxt_s.out = c_out;
    nxt_s.oe_n = c_oe_n;
    nxt_s.pus = c_pus;
    nxt_s.puw = c_puw;
    nxt_s.puv = c_puv;
    nxt_s.pds = c_pds;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.latch <= {NUM_PORTS{LATCH_RST}}; // [RULE21]
      s_ff.mode_a <= tristate_fuse ? '1 : ANALOG_MASK; // [RULE2] [RULE3] [RULE4]
      s_ff.ctrl <= CTRL_RST;
      s_ff.gpi_en <= GPI_RST;
      s_ff.oe_n <= '1;
      s_ff.awready <= 1'b1;
      s_ff.wready <= 1'b1;
      s_ff.arready <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign awready = s_ff.awready;
  assign wready = s_ff.wready;
  assign bvalid = s_ff.bvalid;
  assign bresp = s_ff.bresp;
  assign arready = s_ff.arready;
  assign rvalid = s_ff.rvalid;
  assign rdata = s_ff.rdata;
  assign rresp = s_ff.rresp;
  assign pin_out = s_ff.out;
  assign pin_oe_n = s_ff.oe_n;
  assign pu_strong = s_ff.pus;
  assign pu_weak = s_ff.puw;
  assign pu_very_weak = s_ff.puv;
  assign pd_strong = s_ff.pds;

  // ==========================================================
  // Checks per pin
  for (genvar k = 0; k < NUM_PINS; k++) begin : g_chk
    a_strong_two: assert property ( // [RULE9]
      @(posedge aclk) disable iff (!aresetn)
      ($rose(s_ff.latch[k]) && $past(m_qb[k]) && m_qb[k] && !lost[k])
      ##1 (m_qb[k] && s_ff.latch[k] && !lost[k])
      |-> pu_strong[k] ##1 pu_strong[k] ##1 (!pu_strong[k] || $past(m_pp[k])))
      else $error("strong pull-up pulse not two clocks");

    a_push_pull: assert property ( // [RULE13]
      @(posedge aclk) disable iff (!aresetn)
      (m_pp[k] && !lost[k]) |=> (pu_strong[k] == $past(s_ff.latch[k]))
      && (pd_strong[k] != $past(s_ff.latch[k])) && !pin_oe_n[k])
      else $error("push-pull drive wrong");

    a_open_drain: assert property ( // [RULE12]
      @(posedge aclk) disable iff (!aresetn)
      (m_od[k] && !lost[k]) |=> !pu_strong[k] && !pu_weak[k] && !pu_very_weak[k]
      && (pd_strong[k] == !$past(s_ff.latch[k])) && (pin_oe_n[k] == $past(s_ff.latch[k])))
      else $error("open-drain drive wrong");

    a_input_hiz: assert property ( // [RULE11]
      @(posedge aclk) disable iff (!aresetn)
      m_in[k] |=> pin_oe_n[k] && !(pu_strong[k] || pu_weak[k] || pu_very_weak[k]
      || pd_strong[k]))
      else $error("input-only pin is driven");

    a_qb_pulls: assert property ( // [RULE7] [RULE8] [RULE10]
      @(posedge aclk) disable iff (!aresetn)
      (m_qb[k] && !lost[k]) |=> (pu_very_weak[k] == $past(s_ff.latch[k]))
      && (pu_weak[k] == ($past(s_ff.latch[k]) && $past(pin_in[k])))
      && (pd_strong[k] == !$past(s_ff.latch[k])))
      else $error("quasi-bidirectional pulls wrong");

    a_pdown_gate: assert property ( // [RULE5] [RULE6]
      @(posedge aclk) disable iff (!aresetn)
      (s_ff.ctrl[CTRL_PDOWN] && !WAKE_MASK[k] && !gpi_mask[k]) |-> !sensed[k])
      else $error("input buffer live in power-down");

    a_analog_gate: assert property ( // [RULE14] [RULE15]
      @(posedge aclk) disable iff (!aresetn)
      (m_in[k] && ((cmp_on && CMP_MASK[k]) || (adc_on && ADC_MASK[k]))) |-> !sensed[k])
      else $error("analog pin digital input not disabled");

    a_dac_force: assert property ( // [RULE16]
      @(posedge aclk) disable iff (!aresetn)
      (dac_on && DAC_MASK[k]) |=> pin_oe_n[k] && !pd_strong[k] && !pu_strong[k])
      else $error("DAC pin not forced input-only");

    a_reset_in: assert property ( // [RULE2] [RULE4]
      @(posedge aclk) disable iff (!aresetn)
      (!$past(aresetn) && (ANALOG_MASK[k] || $past(tristate_fuse))) |-> m_in[k])
      else $error("pin not input-only after reset");

    a_reset_qb: assert property ( // [RULE3] [RULE21]
      @(posedge aclk) disable iff (!aresetn)
      (!$past(aresetn) && !ANALOG_MASK[k] && !$past(tristate_fuse))
      |-> m_qb[k] && s_ff.latch[k])
      else $error("pin not quasi-bidirectional high after reset");
  end

endmodule

// ---- rtl/gpio_bank_pkg.sv ----
// Package: register map, mode codes, pin masks and constants of the I/O port bank
// Functional notes
// [RULE1] - Two mode bits per pin pick quasi-bidir, push-pull, input-only or open-drain.
// [RULE2] - With the tristate fuse set, every pin leaves reset input-only.
// [RULE3] - With the fuse clear, non-analog pins leave reset quasi-bidir, weakly high.
// [RULE4] - Port 0 and port 2 bits 4-7 always leave reset input-only.
// [RULE5] - Power-down disables all input buffers except wake, reset and oscillator pins.
// [RULE6] - Port 1 pins enabled as general interrupts keep inputs in power-down.
// [RULE7] - Quasi-bidir: very weak pull-up on whenever the latch holds one.
// [RULE8] - Quasi-bidir: weak pull-up on only while latch and pin are both high.
// [RULE9] - Quasi-bidir: latch rising turns strong pull-up on for exactly two clocks.
// [RULE10] - Quasi-bidir: latch zero drives the strong pull-down.
// [RULE11] - Input-only: all pull-ups and pull-down off, pin high impedance.
// [RULE12] - Open-drain: no pull-ups, pull-down only while latch holds zero.
// [RULE13] - Push-pull: strong pull-up on latch one, strong pull-down on zero.
// [RULE14] - Port 2 bits 4-7 input-only lose digital input while a comparator runs.
// [RULE15] - Port 0 input-only pins lose digital input while converter runs as ADC.
// [RULE16] - In DAC mode port 2 bits 2 and 3 are forced input-only.
// [RULE17] - Plain port data reads return sensed pin levels.
// [RULE18] - Read-modify-write reads return latch contents, not pins.
// [RULE19] - Single-bit set and clear rewrite the whole eight-bit latch.
// [RULE20] - Usable pins range 35 to 38, lost to clock and reset options.
// [RULE21] - Port latches reset to all ones.
// [RULE22] - Mode and data registers read and write anytime, effective next cycle.
package gpio_bank_pkg;

  localparam int NUM_PORTS = 5;
  localparam int PORT_W = 8;
  localparam int NUM_PINS = 40;
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  localparam int W_KEEP = 16;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int VIEW_BIT = 10;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_P0_LATCH = 8'h80;
  localparam logic [7:0] IDX_P1_LATCH = 8'h90;
  localparam logic [7:0] IDX_P2_LATCH = 8'ha0;
  localparam logic [7:0] IDX_P3_LATCH = 8'hb0;
  localparam logic [7:0] IDX_P4_LATCH = 8'hc0;
  localparam logic [7:0] IDX_P0_MODE_A = 8'hba;
  localparam logic [7:0] IDX_P0_MODE_B = 8'hbb;
  localparam logic [7:0] IDX_P1_MODE_A = 8'hc2;
  localparam logic [7:0] IDX_P1_MODE_B = 8'hc3;
  localparam logic [7:0] IDX_P2_MODE_A = 8'hc4;
  localparam logic [7:0] IDX_P2_MODE_B = 8'hc5;
  localparam logic [7:0] IDX_P3_MODE_A = 8'hc6;
  localparam logic [7:0] IDX_P3_MODE_B = 8'hc7;
  localparam logic [7:0] IDX_P4_MODE_A = 8'hbe;
  localparam logic [7:0] IDX_P4_MODE_B = 8'hbf;
  localparam logic [7:0] IDX_ANALOG_CTRL = 8'hd0;
  localparam logic [7:0] IDX_GPI_EN = 8'hd1;
  localparam logic [7:0] IDX_BIT_OP = 8'hd2;
  localparam logic [7:0] IDX_PIN_COUNT = 8'hd3;

  // ==========================================================
  // Control fields
  localparam int CTRL_CMP_A = 0;
  localparam int CTRL_CMP_B = 1;
  localparam int CTRL_CONV_EN = 2;
  localparam int CTRL_CONV_DAC = 3;
  localparam int CTRL_PDOWN = 4;
  localparam logic [7:0] CTRL_MASK = 8'h1f;
  localparam int BITOP_BIT_LSB = 0;
  localparam int BITOP_PORT_LSB = 4;
  localparam int BITOP_OP_LSB = 8;
  localparam logic [1:0] OP_CLR = 2'h0;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CPL = 2'h2;

  // ==========================================================
  // Modes as {mode_select_bit_a, mode_select_bit_b}
  localparam logic [1:0] MODE_QB = 2'h0;
  localparam logic [1:0] MODE_PP = 2'h1;
  localparam logic [1:0] MODE_IN = 2'h2;
  localparam logic [1:0] MODE_OD = 2'h3;

  // ==========================================================
  // Pin masks, bit p*8+b is port p bit b
  localparam logic [NUM_PINS-1:0] ANALOG_MASK = 40'h0000f000ff;
  localparam logic [NUM_PINS-1:0] CMP_MASK = 40'h0000f00000;
  localparam logic [NUM_PINS-1:0] ADC_MASK = 40'h00000000ff;
  localparam logic [NUM_PINS-1:0] DAC_MASK = 40'h00000c0000;
  localparam logic [NUM_PINS-1:0] WAKE_MASK = 40'h070c000000;
  localparam int GPI_PORT_LSB = 8;
  localparam int XTAL_IN_PIN = 32;
  localparam int XTAL_OUT_PIN = 33;
  localparam int RST_PIN = 34;
  localparam logic [5:0] MAX_IO_PINS = 6'h26;
  localparam logic [1:0] CLK_RC = 2'h0;
  localparam logic [1:0] CLK_EXT = 2'h1;
  localparam logic [1:0] CLK_XTAL = 2'h2;

  // ==========================================================
  // Reset values and bus answers
  localparam logic [PORT_W-1:0] LATCH_RST = 8'hff;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] GPI_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/gpio_pin_cell.sv ----
// Output structure of one port pin, chosen by its mode
`timescale 1ns/100ps
module gpio_pin_cell
  import gpio_bank_pkg::*;
(
  input wire logic [1:0] mode,
  input wire logic latch,
  input wire logic level,
  input wire logic boost,
  input wire logic lost,
  output logic drv_out,
  output logic drv_oe_n,
  output logic pu_strong,
  output logic pu_weak,
  output logic pu_very_weak,
  output logic pd_strong
);

  always_comb begin
    drv_out = 1'b0;
    drv_oe_n = 1'b1;
    pu_strong = 1'b0;
    pu_weak = 1'b0;
    pu_very_weak = 1'b0;
    pd_strong = 1'b0;
    // Pins taken by clock or reset options are left alone
    if (!lost) begin
      case (mode)
        MODE_QB: begin
          pu_very_weak = latch; // [RULE7]
          pu_weak = latch & level; // [RULE8]
          pu_strong = latch & boost; // [RULE9]
          pd_strong = !latch; // [RULE10]
          drv_out = latch;
          drv_oe_n = !(latch & boost) & latch;
        end
        MODE_PP: begin
          pu_strong = latch; // [RULE13]
          pd_strong = !latch; // [RULE13]
          drv_out = latch;
          drv_oe_n = 1'b0;
        end
        MODE_OD: begin
          pd_strong = !latch; // [RULE12]
          drv_oe_n = latch; // [RULE12]
        end
        MODE_IN: begin
          drv_oe_n = 1'b1; // [RULE11]
        end
        default: begin
          drv_oe_n = 1'b1;
        end
      endcase
    end
  end

endmodule

// ---- bench/pin_partner.sv ----
// External circuitry on the port pins: drivers, pull-ups, floating lines
`timescale 1ns/100ps
module pin_partner
  import gpio_bank_pkg::*;
(
  input wire logic aclk,
  input wire logic [NUM_PINS-1:0] ext_en,
  input wire logic [NUM_PINS-1:0] ext_val,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe_n,
  input wire logic [NUM_PINS-1:0] pu_any,
  output logic [NUM_PINS-1:0] pin_in
);
  logic tog_ff = 1'b0;
  // Floating pins toggle so no settled unknown passes for a level
  always @(posedge aclk) tog_ff <= ~tog_ff;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pu_any[i]) pin_in[i] = 1'b1;
      else pin_in[i] = tog_ff;
    end
  end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the configurable port bank
`timescale 1ns/100ps
module tb;
  import gpio_bank_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, r;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, arready, bvalid, rvalid;
  logic [1:0] bresp, rresp, rsp, clk_src_sel = 2'h0;
  logic tristate_fuse = 1'b0, ext_reset_sel = 1'b0;
  logic [39:0] ext_en = '0, ext_val = '0, pin_in, pin_out, pin_oe_n;
  logic [39:0] pu_strong, pu_weak, pu_very_weak, pd_strong;
  logic [7:0] lat1;
  int failures = 0, checks_done = 0, pulse_n = 0, b;
  int seed = 32'hbd47bb36;
  always #4 aclk = ~aclk;
  always @(posedge aclk) if (pu_strong[24] === 1'b1) pulse_n <= pulse_n + 1;
  gpio_port_bank gpio_port_bank_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(1'b1), .tristate_fuse(tristate_fuse), .clk_src_sel(clk_src_sel),
    .ext_reset_sel(ext_reset_sel), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pu_strong(pu_strong), .pu_weak(pu_weak), .pu_very_weak(pu_very_weak),
    .pd_strong(pd_strong));
  pin_partner pin_partner_i (.aclk(aclk), .ext_en(ext_en), .ext_val(ext_val),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pu_any(pu_weak | pu_very_weak | pu_strong),
    .pin_in(pin_in));
  // ==========
  // Bus cycles and comparison
  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    awaddr <= ad(idx);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    arvalid <= 1'b1;
    araddr <= a;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rsp = rresp;
    chk(rdata, e);
  endtask
  // Steady {strong up, very weak up, strong down} of one port per mode
  function automatic logic [31:0] exp_drv(input int m, input logic [7:0] h);
    case (m)
      0: return {16'h0, h, ~h};
      1: return {8'h0, h, 8'h0, ~h};
      2: return 32'h0;
      default: return {24'h0, ~h};
    endcase
  endfunction
  // Steady {level driven, not strongly driven} of one port per mode
  function automatic logic [31:0] exp_pin(input int m, input logic [7:0] h);
    case (m)
      0: return {16'h0, h, h};
      1: return {16'h0, h, 8'h0};
      2: return {16'h0, 8'h0, 8'hff};
      default: return {24'h0, h};
    endcase
  endfunction
  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    tally_and_finish;
  end
  // ==========
  // Scenarios
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(pu_very_weak[15:0]), 32'hff00);
    rc(ad(IDX_P0_MODE_A), 32'hff);
    rc(ad(IDX_P2_MODE_A), 32'hf0);
    rc(ad(IDX_P1_MODE_A), 32'h0);
    rc(ad(IDX_P3_LATCH) + 12'h400, 32'hff);
    for (int m = 0; m < 4; m++) begin
      for (int l = 0; l < 2; l++) begin
        wr(IDX_P3_LATCH, {24'h0, {8{l[0]}}});
        wr(IDX_P3_MODE_A, {24'h0, {8{m[1]}}});
        wr(IDX_P3_MODE_B, {24'h0, {8{m[0]}}});
        repeat (4) @(posedge aclk);
        chk({8'h0, pu_strong[31:24], pu_very_weak[31:24], pd_strong[31:24]},
          exp_drv(m, {8{l[0]}}));
        chk({16'h0, pin_out[31:24], pin_oe_n[31:24]}, exp_pin(m, {8{l[0]}}));
      end
    end
    wr(IDX_P3_LATCH, 32'h0);
    wr(IDX_P3_MODE_A, 32'h0);
    wr(IDX_P3_MODE_B, 32'h0);
    b = pulse_n;
    wr(IDX_P3_LATCH, 32'hff);
    repeat (6) @(posedge aclk);
    chk(32'(pulse_n - b), 32'h2);
    // External device sinks the pin, weak pull-up must let go
    ext_en[24] <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(pu_weak[24]), 32'h0);
    ext_en[24] <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(pu_weak[24]), 32'h1);
    r = $random(seed);
    wr(IDX_P1_MODE_A, 32'hff);
    wr(IDX_P1_LATCH, r);
    lat1 = r[7:0];
    ext_en[23:0] <= 24'hffffff;
    ext_val[23:0] <= {8'ha5, r[15:8], 8'h5a};
    rc(ad(IDX_P1_LATCH), 32'(r[15:8]));
    rc(ad(IDX_P1_LATCH) + 12'h400, 32'(lat1));
    for (int op = 0; op < 3; op++) begin
      b = $random(seed) & 7;
      wr(IDX_BIT_OP, 32'((op << 8) | (1 << 4) | b));
      lat1[b] = (op == 0) ? 1'b0 : (op == 1) ? 1'b1 : ~lat1[b];
      rc(ad(IDX_P1_LATCH) + 12'h400, 32'(lat1));
    end
    wr(IDX_ANALOG_CTRL, 32'h4);
    rc(ad(IDX_P0_LATCH), 32'h0);
    wr(IDX_ANALOG_CTRL, 32'h1);
    rc(ad(IDX_P0_LATCH), 32'h5a);
    rc(ad(IDX_P2_LATCH), 32'h05);
    wr(IDX_ANALOG_CTRL, 32'h2);
    rc(ad(IDX_P2_LATCH), 32'h05);
    // Open-drain with latch one keeps the digital input while a comparator runs
    wr(IDX_P2_MODE_B, 32'hf0);
    rc(ad(IDX_P2_LATCH), 32'ha5);
    wr(IDX_P2_MODE_B, 32'h0);
    wr(IDX_P2_LATCH, 32'h0);
    wr(IDX_ANALOG_CTRL, 32'hc);
    repeat (3) @(posedge aclk);
    chk(32'(pd_strong[23:16]), 32'h03);
    rc(ad(IDX_P0_LATCH), 32'h5a);
    ext_en[31:24] <= 8'hff;
    ext_val[31:24] <= 8'hff;
    wr(IDX_GPI_EN, 32'h01);
    wr(IDX_ANALOG_CTRL, 32'h10);
    rc(ad(IDX_P3_LATCH), 32'h0c);
    rc(ad(IDX_P1_LATCH), 32'(r[8]));
    for (int k = 0; k < 6; k++) begin
      clk_src_sel <= 2'(k % 3);
      ext_reset_sel <= (k >= 3);
      @(posedge aclk);
      rc(ad(IDX_PIN_COUNT), 32'(38 - k % 3 - k / 3));
    end
    rc(12'hffc, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(8'hff, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(IDX_PIN_COUNT, 32'h0);
    chk(32'(rsp), 32'(RESP_OKAY));
    // Second reset with the fuse set
    tristate_fuse <= 1'b1;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(pu_very_weak[31:0], 32'h0);
    rc(ad(IDX_P1_MODE_A), 32'hff);
    tally_and_finish;
  end
endmodule
